// [bps_cfg.svh]
`ifndef BPS_CFG_SVH
`define BPS_CFG_SVH
// ****************************************************************
// clock and timing
// ****************************************************************
`define BPS_CLK_KHZ      250000
`define BPS_SW_KHZ       300
`define BPS_SW_DIV       (`BPS_CLK_KHZ / `BPS_SW_KHZ)
`define BPS_SS_TIME_US   2000
`define BPS_SS_CYCLES    (`BPS_SS_TIME_US * (`BPS_CLK_KHZ / 1000))
`define BPS_FLT_TIME_NS  30000
`define BPS_FLT_CYCLES   ((`BPS_FLT_TIME_NS * (`BPS_CLK_KHZ / 1000)) / 1000)
`define BPS_OC_PERSIST   10
`define BPS_EVENT_LIMIT  3
`define BPS_REF_BITS     8
`define BPS_SYNC_RESET   6'h00
`endif

// [bps_pkg.sv]
package bps_pkg;
    typedef enum logic [2:0] {
        BPS_ST_RESET = 3'h0,
        BPS_ST_WAIT  = 3'h1,
        BPS_ST_SOFT  = 3'h2,
        BPS_ST_RUN   = 3'h3,
        BPS_ST_LATCH = 3'h4
    } bps_state_t;

    // digitized comparator outputs, all asynchronous to ref_clk
    typedef struct packed {
        logic control_supply;        // above start-up / not below power-down
        logic current_limit_enable;  // pin above enable threshold
        logic phase_below_limit;     // switch-node sense below limit level
        logic overvoltage_detect;    // feedback above overvoltage level
        logic undervoltage_detect;   // feedback below undervoltage level
        logic pwm_on;                // modulator requests upper on
    } bps_cmp_t;

    typedef struct packed {
        logic upper;                 // high-side gate drive
        logic lower;                 // low-side gate drive
    } bps_drive_t;

    typedef struct packed {
        bps_state_t state;           // sequencer state
        logic       latched_off;     // protection latch-off
        logic [1:0] oc_events;       // overcurrent trips so far
        logic [1:0] uv_events;       // undervoltage events so far
    } bps_status_t;
endpackage

// [bps_persist.sv]
`timescale 1ns/1ns
`include "bps_cfg.svh"
module bps_persist #(
    parameter int LIMIT = 10,
    parameter int W     = $clog2(LIMIT + 1)
) (
    input  wire logic ref_clk,   // system clock
    input  wire logic reset,     // synchronous, active high
    input  wire logic clear,     // restart the count
    input  wire logic sample,    // one-cycle sampling enable
    input  wire logic cond,      // condition under test
    output logic      active,    // condition has persisted LIMIT samples
    output logic      fire       // pulse on reaching LIMIT
);
    localparam logic [W-1:0] LIM = W'(LIMIT);
    logic [W-1:0] cnt_r;

    initial begin
        if (LIMIT < 1) $error("bps_persist: LIMIT must be at least 1");
    end

    always_ff @(posedge ref_clk) begin
        if (reset || clear) begin
            cnt_r <= '0;
        end else if (sample) begin
            if (!cond) begin
                cnt_r <= '0;
            end else if (cnt_r != LIM) begin
                cnt_r <= cnt_r + W'(1);
            end
        end
    end

    assign fire   = sample && cond && !clear && (cnt_r == LIM - W'(1));
    assign active = (cnt_r == LIM);
endmodule

// [bps_top.sv]
`timescale 1ns/1ns
`include "bps_cfg.svh"
module bps_top #(
    parameter int SS_CYCLES  = `BPS_SS_CYCLES,
    parameter int FLT_CYCLES = `BPS_FLT_CYCLES,
    parameter int REF_BITS   = `BPS_REF_BITS
) (
    input  wire logic          ref_clk,   // 250 MHz clock
    input  wire logic          reset,     // synchronous, active high
    input  bps_pkg::bps_cmp_t  cmp_in,    // raw comparator outputs
    output bps_pkg::bps_drive_t gate,     // gate drive outputs
    output logic [REF_BITS-1:0] ref_code, // soft-start reference code
    output bps_pkg::bps_status_t status   // sequencer status
);
    localparam int SW_DIV = `BPS_SW_DIV;
    localparam int SS_STEP = SS_CYCLES / (2 ** REF_BITS);
    localparam int SSW = $clog2(SS_STEP + 1);
    localparam logic [REF_BITS-1:0] REF_FULL = '1;
    localparam logic [1:0] EV_LAST = 2'(`BPS_EVENT_LIMIT - 1);

    initial begin
        if (SS_STEP < 1) $error("bps_top: SS_CYCLES too small");
        if (FLT_CYCLES < 1) $error("bps_top: FLT_CYCLES too small");
    end

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    bps_pkg::bps_cmp_t meta_r;
    bps_pkg::bps_cmp_t cmp_r;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta_r <= `BPS_SYNC_RESET;
            cmp_r  <= `BPS_SYNC_RESET;
        end else begin
            meta_r <= cmp_in;
            cmp_r  <= meta_r;
        end
    end

    // ****************************************************************
    // switching-rate divider
    // ****************************************************************
    logic [$clog2(SW_DIV)-1:0] div_r;
    logic                      sw_tick;
    assign sw_tick = (div_r == ($clog2(SW_DIV))'(SW_DIV - 1));
    always_ff @(posedge ref_clk) begin
        if (reset || sw_tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + ($clog2(SW_DIV))'(1);
        end
    end

    // ****************************************************************
    // protection filters
    // ****************************************************************
    bps_pkg::bps_state_t state_r;
    logic switching;
    logic hi_r;
    logic [1:0] hi_pipe_r;
    logic lo_r;
    logic oc_seen_r;
    logic oc_seen_now;
    logic oc_block_r;
    logic oc_fire;
    logic ov_fire;
    logic uv_fire;
    logic uv_active;
    logic [1:0] oc_cnt_r;
    logic [1:0] uv_cnt_r;
    logic oc_sense;
    assign switching = (state_r == bps_pkg::BPS_ST_SOFT) ||
                       (state_r == bps_pkg::BPS_ST_RUN);
    // sense sample lines up with the synchroniser delay of the drive
    assign oc_sense = hi_r && hi_pipe_r[1] && cmp_r.phase_below_limit;
    assign oc_seen_now = oc_seen_r || oc_sense;
    always_ff @(posedge ref_clk) begin
        if (reset || !switching || sw_tick) begin
            oc_seen_r <= 1'b0;
        end else if (oc_sense) begin
            oc_seen_r <= 1'b1;
        end
    end
    bps_persist #(.LIMIT(`BPS_OC_PERSIST)) u_oc_filt (
        .ref_clk (ref_clk),
        .reset   (reset),
        .clear   (!switching || oc_block_r),
        .sample  (sw_tick),
        .cond    (oc_seen_now),
        .active  (),
        .fire    (oc_fire)
    );
    bps_persist #(.LIMIT(FLT_CYCLES + 1)) u_ov_filt (
        .ref_clk (ref_clk),
        .reset   (reset),
        .clear   (!switching),
        .sample  (1'b1),
        .cond    (cmp_r.overvoltage_detect),
        .active  (),
        .fire    (ov_fire)
    );
    bps_persist #(.LIMIT(FLT_CYCLES + 1)) u_uv_filt (
        .ref_clk (ref_clk),
        .reset   (reset),
        .clear   (state_r != bps_pkg::BPS_ST_RUN),
        .sample  (1'b1),
        .cond    (cmp_r.undervoltage_detect),
        .active  (uv_active),
        .fire    (uv_fire)
    );
    // upper off for the whole next switching cycle; set wins over clear
    always_ff @(posedge ref_clk) begin
        if (reset || !switching) begin
            oc_block_r <= 1'b0;
        end else if (oc_fire) begin
            oc_block_r <= 1'b1;
        end else if (sw_tick) begin
            oc_block_r <= 1'b0;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (reset || state_r == bps_pkg::BPS_ST_RESET) begin
            oc_cnt_r <= 2'h0;
            uv_cnt_r <= 2'h0;
        end else begin
            if (oc_fire && oc_cnt_r != EV_LAST + 2'h1) begin
                oc_cnt_r <= oc_cnt_r + 2'h1;
            end
            if (uv_fire && uv_cnt_r != EV_LAST + 2'h1) begin
                uv_cnt_r <= uv_cnt_r + 2'h1;
            end
        end
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    logic trip_latch;
    logic [SSW-1:0] step_r;
    assign trip_latch = ov_fire ||
                        (oc_fire && oc_cnt_r == EV_LAST) ||
                        (uv_fire && uv_cnt_r == EV_LAST);
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_r <= bps_pkg::BPS_ST_RESET;
        end else if (!cmp_r.control_supply) begin
            state_r <= bps_pkg::BPS_ST_RESET;
        end else begin
            case (state_r)
                bps_pkg::BPS_ST_RESET: begin
                    state_r <= bps_pkg::BPS_ST_WAIT;
                end
                bps_pkg::BPS_ST_WAIT: begin
                    if (cmp_r.current_limit_enable) begin
                        state_r <= bps_pkg::BPS_ST_SOFT;
                    end
                end
                bps_pkg::BPS_ST_SOFT, bps_pkg::BPS_ST_RUN: begin
                    if (trip_latch) begin
                        state_r <= bps_pkg::BPS_ST_LATCH;
                    end else if (!cmp_r.current_limit_enable) begin
                        state_r <= bps_pkg::BPS_ST_WAIT;
                    end else if (ref_code == REF_FULL) begin
                        state_r <= bps_pkg::BPS_ST_RUN;
                    end
                end
                bps_pkg::BPS_ST_LATCH: begin
                    state_r <= bps_pkg::BPS_ST_LATCH;
                end
                default: begin
                    state_r <= bps_pkg::BPS_ST_RESET;
                end
            endcase
        end
    end

    // ****************************************************************
    // soft-start reference ramp
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (reset || !switching) begin
            step_r   <= '0;
            ref_code <= '0;
        end else if (ref_code != REF_FULL) begin
            if (step_r == SSW'(SS_STEP - 1)) begin
                step_r   <= '0;
                ref_code <= ref_code + REF_BITS'(1);
            end else begin
                step_r <= step_r + SSW'(1);
            end
        end
    end

    // ****************************************************************
    // gate drive with break-before-make
    // ****************************************************************
    logic want_hi;
    logic want_lo;
    logic gate_ok;
    assign gate_ok = switching && !trip_latch && !uv_active && !uv_fire;
    assign want_hi = gate_ok && cmp_r.pwm_on && !oc_block_r && !oc_fire;
    assign want_lo = gate_ok && !cmp_r.pwm_on;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hi_r <= 1'b0;
            lo_r <= 1'b0;
            hi_pipe_r <= 2'h0;
        end else begin
            hi_r <= want_hi && !lo_r;
            lo_r <= want_lo && !hi_r;
            hi_pipe_r <= {hi_pipe_r[0], hi_r};
        end
    end
    assign gate.upper         = hi_r;
    assign gate.lower         = lo_r;
    assign status.state       = state_r;
    assign status.latched_off = (state_r == bps_pkg::BPS_ST_LATCH);
    assign status.oc_events   = oc_cnt_r;
    assign status.uv_events   = uv_cnt_r;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking sample_clk @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_gate_no_overlap: assert property (!(hi_r && lo_r))
        else $error("both gate drives high");
    a_start_supply: assert property (
        $rose(state_r == bps_pkg::BPS_ST_WAIT) &&
        $past(state_r) == bps_pkg::BPS_ST_RESET |-> $past(cmp_r.control_supply))
        else $error("left reset without good supply");
    a_supply_drop: assert property (
        !cmp_r.control_supply |=> state_r == bps_pkg::BPS_ST_RESET ##1
        (!hi_r && !lo_r))
        else $error("supply loss did not reset");
    a_no_pulse_idle: assert property (
        state_r == bps_pkg::BPS_ST_WAIT |=> !hi_r && !lo_r)
        else $error("pulses while waiting for enable");
    a_enable_stop: assert property (
        !cmp_r.current_limit_enable |-> ##2 (!hi_r && !lo_r))
        else $error("switching with enable low");
    a_ramp_hold: assert property (
        state_r == bps_pkg::BPS_ST_RUN |-> ref_code == REF_FULL)
        else $error("reference not full in run");
    a_ramp_step: assert property (
        switching && $past(switching) && ref_code != $past(ref_code) |->
        ref_code == $past(ref_code) + REF_BITS'(1) &&
        $past(step_r) == SSW'(SS_STEP - 1))
        else $error("bad soft-start step");
    a_oc_qualified: assert property ($rose(oc_seen_r) |-> $past(hi_r))
        else $error("overcurrent seen with upper off");
    a_oc_cut: assert property (oc_fire |=> !hi_r [*2])
        else $error("upper drive not cut on trip");
    a_oc_latch: assert property (
        oc_fire && oc_cnt_r == EV_LAST && cmp_r.control_supply |=>
        state_r == bps_pkg::BPS_ST_LATCH)
        else $error("third overcurrent did not latch");
    a_latch_hold: assert property (
        state_r == bps_pkg::BPS_ST_LATCH && cmp_r.control_supply |=>
        state_r == bps_pkg::BPS_ST_LATCH && !hi_r && !lo_r)
        else $error("latch released without power cycle");
    a_ov_latch: assert property (
        ov_fire && cmp_r.control_supply |=> !hi_r && !lo_r &&
        state_r == bps_pkg::BPS_ST_LATCH)
        else $error("overvoltage did not latch off");
    a_uv_gates_off: assert property (uv_active |=> !hi_r && !lo_r)
        else $error("gates on during undervoltage");
    a_reset_clear: assert property (
        state_r == bps_pkg::BPS_ST_RESET &&
        $past(state_r) == bps_pkg::BPS_ST_RESET |->
        oc_cnt_r == 2'h0 && uv_cnt_r == 2'h0 && ref_code == '0)
        else $error("counters not cleared in reset");

    c_reach_run: cover property ($rose(state_r == bps_pkg::BPS_ST_RUN));
    c_oc_latch: cover property (oc_fire && oc_cnt_r == EV_LAST);
    c_ov_latch: cover property (ov_fire);
    c_uv_event: cover property (uv_fire);
endmodule

// [bps_cmp_model.sv]
`timescale 1ns/1ns
// ****************************************************************
// comparator front end seen by the sequencer
// ****************************************************************
module bps_cmp_model (
    input  wire logic           ref_clk,   // 250 MHz clock
    input  wire logic           supply_on, // supply above start-up
    input  wire logic           enable_on, // enable pin released high
    input  wire logic           overload,  // load above trip level
    input  wire logic [1:0]     fdbk_mode, // 0 normal 1 over 2 under
    input  wire logic [9:0]     duty,      // upper-on cycles per period
    input  bps_pkg::bps_drive_t gate,      // device gate drives
    output bps_pkg::bps_cmp_t   cmp        // comparator levels
);
    logic [9:0] cnt_r;

    initial cnt_r = 10'h000;

    // modulator period of 833 clocks
    always @(posedge ref_clk) begin
        cnt_r <= (cnt_r == 10'h340) ? 10'h000 : cnt_r + 10'h001;
    end

    assign cmp.control_supply       = supply_on;
    assign cmp.current_limit_enable = enable_on;
    // switch node sits low whenever the upper switch is off
    assign cmp.phase_below_limit    = overload | ~gate.upper;
    assign cmp.overvoltage_detect   = (fdbk_mode == 2'h1);
    assign cmp.undervoltage_detect  = (fdbk_mode == 2'h2);
    assign cmp.pwm_on               = (cnt_r < duty);
endmodule

// [buck_protection_sequencer_tb.sv]
`timescale 1ns/1ns
module buck_protection_sequencer_tb;
    localparam int SS  = 2560;
    localparam int FLT = 20;
    localparam int PER = 833;

    logic                 ref_clk;
    logic                 reset;
    logic                 supply_on;
    logic                 enable_on;
    logic                 overload;
    logic [1:0]           fdbk_mode;
    logic [9:0]           duty;
    logic                 quiet;
    bps_pkg::bps_cmp_t    cmp;
    bps_pkg::bps_drive_t  gate;
    logic [7:0]           ref_code;
    bps_pkg::bps_status_t status;
    int                   n_errors;
    int                   checked;
    int                   t;
    logic [31:0]          seed;

    bps_top #(
        .SS_CYCLES  (SS),
        .FLT_CYCLES (FLT),
        .REF_BITS   (8)
    ) dut_u (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .cmp_in   (cmp),
        .gate     (gate),
        .ref_code (ref_code),
        .status   (status)
    );

    bps_cmp_model cmp_u (
        .ref_clk   (ref_clk),
        .supply_on (supply_on),
        .enable_on (enable_on),
        .overload  (overload),
        .fdbk_mode (fdbk_mode),
        .duty      (duty),
        .gate      (gate),
        .cmp       (cmp)
    );

    initial ref_clk = 1'b0;
    always #2 ref_clk = ~ref_clk;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    // cycles from ramp start to full reference
    function automatic int ramp_len(input int ss);
        return (ss / 256) * 255;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wait_state(input bps_pkg::bps_state_t s, input int lim);
        t = 0;
        while (status.state !== s && t < lim) begin
            cyc(1);
            t++;
        end
    endtask

    task automatic rise(input int lim);
        t = 0;
        while (gate.upper !== 1'b0 && t < lim) begin
            cyc(1);
            t++;
        end
        while (gate.upper !== 1'b1 && t < lim) begin
            cyc(1);
            t++;
        end
    endtask

    task automatic power_up();
        supply_on = 1'b1;
        enable_on = 1'b1;
        wait_state(bps_pkg::BPS_ST_SOFT, 10);
        chk(status.state, bps_pkg::BPS_ST_SOFT);
        wait_state(bps_pkg::BPS_ST_RUN, SS + 100);
        chk(32'(t >= ramp_len(SS) - 10 && t <= ramp_len(SS) + 10), 32'h1);
        chk(ref_code, 32'hff);
    endtask

    task automatic power_cycle();
        quiet = 1'b0;
        supply_on = 1'b0;
        wait_state(bps_pkg::BPS_ST_RESET, 6);
        cyc(2);
        chk(status, 32'h0);
        chk(gate, 32'h0);
        power_up();
    endtask

    task automatic glitch(input logic [1:0] mode);
        seed = xs(seed);
        duty = 10'h064 + {1'b0, seed[8:0]};
        fdbk_mode = mode;
        cyc(1 + int'(seed[31:28] % 4'hc));
        fdbk_mode = 2'h0;
        cyc(40);
        chk(status.state, bps_pkg::BPS_ST_RUN);
    endtask

    task automatic done(input string s);
        $display("test %s ended, mismatches %0d", s, n_errors);
    endtask

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // monitors
    // ****************************************************************
    always @(negedge ref_clk) begin
        if (gate.upper === 1'b1) begin
            chk(gate.lower, 32'h0);
        end
        if (quiet) begin
            chk(gate, 32'h0);
        end
    end

    initial begin
        #320000;
        n_errors++;
        stop_test();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        n_errors = 0;
        checked = 0;
        seed = 32'hb3401c7c;
        reset = 1'b1;
        supply_on = 1'b0;
        enable_on = 1'b0;
        overload = 1'b0;
        fdbk_mode = 2'h0;
        duty = 10'h190;
        quiet = 1'b0;
        cyc(3);
        reset = 1'b0;
        chk(status, 32'h0);
        chk(ref_code, 32'h0);
        quiet = 1'b1;
        cyc(20);
        chk(status.state, bps_pkg::BPS_ST_RESET);
        supply_on = 1'b1;
        wait_state(bps_pkg::BPS_ST_WAIT, 5);
        cyc(50);
        chk(status.state, bps_pkg::BPS_ST_WAIT);
        quiet = 1'b0;
        power_up();
        cyc(100);
        chk(ref_code, 32'hff);
        rise(2000);
        rise(2000);
        chk(t, PER);
        done("startup");
        enable_on = 1'b0;
        cyc(5);
        chk(gate, 32'h0);
        chk(status.state, bps_pkg::BPS_ST_WAIT);
        enable_on = 1'b1;
        wait_state(bps_pkg::BPS_ST_SOFT, 6);
        chk(ref_code, 32'h0);
        wait_state(bps_pkg::BPS_ST_RUN, SS + 100);
        done("enable");
        repeat (4) glitch(2'h1);
        fdbk_mode = 2'h1;
        cyc(FLT + 8);
        chk(status.latched_off, 32'h1);
        chk(gate, 32'h0);
        fdbk_mode = 2'h0;
        quiet = 1'b1;
        enable_on = 1'b0;
        cyc(40);
        enable_on = 1'b1;
        cyc(40);
        chk(status.state, bps_pkg::BPS_ST_LATCH);
        power_cycle();
        done("overvoltage");
        cyc(12 * PER);
        chk(status.oc_events, 32'h0);
        overload = 1'b1;
        t = 0;
        while (status.oc_events !== 2'h1 && t < 14 * PER) begin
            cyc(1);
            t++;
        end
        chk(32'(t > 9 * PER && t < 12 * PER), 32'h1);
        cyc(2);
        chk(gate.upper, 32'h0);
        wait_state(bps_pkg::BPS_ST_LATCH, 30 * PER);
        chk(status.state, bps_pkg::BPS_ST_LATCH);
        quiet = 1'b1;
        cyc(2 * PER);
        overload = 1'b0;
        power_cycle();
        done("overcurrent");
        repeat (3) glitch(2'h2);
        chk(status.uv_events, 32'h0);
        for (int k = 1; k <= 3; k++) begin
            fdbk_mode = 2'h2;
            cyc(FLT + 8);
            chk(gate, 32'h0);
            if (k < 3) begin
                chk(status.uv_events, k);
            end
            fdbk_mode = 2'h0;
            cyc(300);
        end
        chk(status.state, bps_pkg::BPS_ST_LATCH);
        done("undervoltage");
        stop_test();
    end
endmodule
